// file: rtl/rsr_pkg.sv
// Package for the reader status, mask, strength and test register bank.
// Assumes an 8-bit register port driven by the host interface logic.
`default_nettype none
package rsr_pkg;
   localparam logic [7:0] RSR_ADDR_MASK     = 8'h0D;
   localparam logic [7:0] RSR_ADDR_POS_LO   = 8'h0E;
   localparam logic [7:0] RSR_ADDR_STRENGTH = 8'h0F;
   localparam logic [7:0] RSR_ADDR_TEST1    = 8'h1A;
   localparam logic [7:0] RSR_ADDR_TEST2    = 8'h1B;
   localparam logic [7:0] RSR_MASK_RESET    = 8'h3E;
   localparam logic [7:0] RSR_ZERO_RESET    = 8'h00;
   // Enable bit positions in the mask register
   localparam int RSR_EN_FIFO   = 5;
   localparam int RSR_EN_CRC    = 4;
   localparam int RSR_EN_PARITY = 3;
   localparam int RSR_EN_FRAME  = 2;
   localparam int RSR_EN_COLL   = 1;
   localparam int RSR_EN_NORESP = 0;
   // Test register 1 fields
   localparam int RSR_T1_KEY_IN  = 7;
   localparam int RSR_T1_SUB_OUT = 6;
   localparam int RSR_T1_DIRECT  = 5;
   localparam int RSR_T1_STAGE   = 4;
   localparam int RSR_T1_ATT2    = 3;
   localparam int RSR_T1_ATT1    = 2;
   localparam int RSR_T1_FOLLOW  = 1;
   localparam int RSR_T1_AGC     = 0;
   // Test register 2 fields
   localparam int RSR_T2_CARRIER = 7;
   localparam int RSR_T2_IO_HI   = 3;
   localparam int RSR_T2_IO_LO   = 2;
   localparam int RSR_T2_DEC     = 1;
   localparam int RSR_T2_FASTCLK = 0;
   // Strength register fields
   localparam int RSR_OSC_BIT    = 6;
   // Oscillator settle time
   localparam int RSR_CLK_MHZ    = 100;
   localparam int RSR_OSC_US     = 200;
   localparam int RSR_OSC_CYCLES = RSR_OSC_US * RSR_CLK_MHZ;
   localparam int RSR_OSC_CW     = 15;
endpackage
`default_nettype wire

// file: rtl/rsr_peak_hold.sv
// Peak hold of one 3-bit strength code.
// Assumes the level code is synchronous to sys_clk.
`default_nettype none
module rsr_peak_hold
   import rsr_pkg::*;
(
   input  wire logic       sys_clk, // System clock
   input  wire logic       rst,     // Synchronous reset
   input  wire logic       clear,   // Restart measurement
   input  wire logic       sample,  // Level code is valid
   input  wire logic [2:0] level,   // Present level code
   output logic      [2:0] peak     // Held peak
);
   logic [2:0] peak_q;
   wire        higher = sample && (level > peak_q);
   assign peak = peak_q;

   always_ff @(posedge sys_clk) begin
      if (rst || clear) begin
         peak_q <= 3'h0;
      end else if (higher) begin
         peak_q <= level;
      end
   end
endmodule
`default_nettype wire

// file: rtl/rsr_regs.sv
// Status, interrupt mask, signal strength and test register bank.
// Assumes a host port that issues one-cycle read and write strobes and
// samples rd_data in the cycle after a read strobe.
// Notes on behaviour
// - Upper hit position bits clear after read
// - Mask resets to 3E, no-response disabled
// - Ten-bit position split over two registers
// - Low position resets zero, clears on read
// - Position also captures error bit positions
// - Per-source enables gate the interrupt request
// - Strength holds demodulated envelope peak
// - Strength cleared when transmission begins
// - Three-bit code, seven 4 dB steps
// - Main bits 2..0, auxiliary bits 5..3
// - Auxiliary measures input b unless swapped
// - Bit 6 reports oscillator stable
// - Keying pin becomes decoder input
// - Subcarrier out, direct keying with rx clear
// - Stage select picks first or second stage
// - Attenuate bits cut stage gain 6 dB
// - Gain test shows gain level in main
// - Test registers reset to zero
// - Test mode ends on stop, bits cleared
// - Fast coder clocking from carrier clock
// - Status read clears flags and request line
`default_nettype none
module rsr_regs
   import rsr_pkg::*;
(
   input  wire logic       sys_clk,         // 100 MHz clock
   input  wire logic       rst,             // Power-on or chip enable low
   input  wire logic [7:0] addr,            // Register address
   input  wire logic       wr_en,           // Write strobe
   input  wire logic [7:0] wr_data,         // Write data
   input  wire logic       rd_en,           // Read strobe
   output logic      [7:0] rd_data,         // Read data, registered
   input  wire logic       stop_cond,       // Host stop condition
   input  wire logic       tx_start,        // Transmission begins
   input  wire logic       rx_active,       // Reception in progress
   input  wire logic       hit_event,       // Collision or error seen
   input  wire logic [9:0] hit_position,    // Bit position of that event
   input  wire logic [5:0] irq_flags,       // Status flags in bit order
   input  wire logic       irq_status_rd,   // Status register read
   output logic            irq,             // Interrupt request line
   input  wire logic [2:0] level_a,         // Envelope code, input a
   input  wire logic [2:0] level_b,         // Envelope code, input b
   input  wire logic [2:0] gain_level,      // Automatic gain code
   input  wire logic       input_swap,      // Chip state swap option
   input  wire logic       onoff_keying_pin, // Keying pin level
   output logic            decoder_in,      // Decoder digital input
   output logic            keying_pin_as_decoder_input, // Pin reused
   input  wire logic       rx_subcarrier,   // Receiver subcarrier
   input  wire logic       tx_modulation,   // Normal modulation
   output logic            tx_keying_pin,   // Modulation pin out
   output logic            rx_clear,        // Receiver reset
   output logic            stage_select,    // 1 selects second stage
   output logic            stage_one_attenuate, // First stage -6 dB
   output logic            stage_two_attenuate, // Second stage -6 dB
   output logic            follower_test,   // Input follower test
   output logic            carrier_level_check, // Level test
   output logic            test_mode,       // Device in test mode
   output logic            decoder_test,    // Decoder test mode
   output logic            fast_coder_clocking // Coders on carrier clock
);
   logic [7:0]  mask_q;
   logic [7:0]  pos_lo_q;
   logic [7:0]  test1_q;
   logic [7:0]  test2_q;
   logic [7:0]  rd_data_q;
   logic [RSR_OSC_CW-1:0] osc_cnt_q;
   logic        osc_ok_q;
   logic [2:0]  main_peak;
   logic [2:0]  aux_peak;
   logic [5:0]  pending_q;
   logic        irq_q;

   wire sel_mask  = (addr == RSR_ADDR_MASK);
   wire sel_pos   = (addr == RSR_ADDR_POS_LO);
   wire sel_str   = (addr == RSR_ADDR_STRENGTH);
   wire sel_t1    = (addr == RSR_ADDR_TEST1);
   wire sel_t2    = (addr == RSR_ADDR_TEST2);
   wire rd_mask   = rd_en && sel_mask;
   wire rd_pos    = rd_en && sel_pos;

   // Input swap moves the auxiliary channel onto input a
   wire [2:0] aux_level = input_swap ? level_a : level_b;

   rsr_peak_hold main_hold (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clear   (tx_start),
      .sample  (rx_active),
      .level   (level_a),
      .peak    (main_peak)
   );

   rsr_peak_hold aux_hold (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clear   (tx_start),
      .sample  (rx_active),
      .level   (aux_level),
      .peak    (aux_peak)
   );

   wire [2:0] main_shown = test1_q[RSR_T1_AGC] ? gain_level
                                               : main_peak;
   wire [7:0] strength_word = {1'b0, osc_ok_q, aux_peak,
                               main_shown};

   // Mask register: enables written, position bits from hardware
   wire [7:0] mask_wr = {mask_q[7:6], wr_data[5:0]};
   // A new event outranks the read clear so it is not lost
   wire [1:0] hi_next = hit_event ? hit_position[9:8]
                      : (rd_mask ? 2'h0 : mask_q[7:6]);
   wire [5:0] en_next = (wr_en && sel_mask) ? mask_wr[5:0]
                                            : mask_q[5:0];
   wire [7:0] lo_next = hit_event ? hit_position[7:0]
                      : (rd_pos ? 8'h00 : pos_lo_q);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mask_q   <= RSR_MASK_RESET;
         pos_lo_q <= RSR_ZERO_RESET;
      end else begin
         mask_q   <= {hi_next, en_next};
         pos_lo_q <= lo_next;
      end
   end

   // Test registers
   wire [7:0] test2_wr  = wr_data;
   wire       t2_write  = wr_en && sel_t2;
   // Stop ends test mode; a write in the same cycle still lands
   wire [7:0] t2_after_stop = stop_cond ? (test2_q & 8'hF1) : test2_q;
   wire [7:0] test2_next = t2_write ? test2_wr : t2_after_stop;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         test1_q <= RSR_ZERO_RESET;
         test2_q <= RSR_ZERO_RESET;
      end else begin
         if (wr_en && sel_t1) begin
            test1_q <= wr_data;
         end
         test2_q <= test2_next;
      end
   end

   // Oscillator start-up timer
   wire osc_done = (osc_cnt_q == RSR_OSC_CW'(RSR_OSC_CYCLES - 1));
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         osc_cnt_q <= '0;
         osc_ok_q  <= 1'b0;
      end else if (!osc_ok_q) begin
         osc_cnt_q <= osc_cnt_q + RSR_OSC_CW'(1);
         osc_ok_q  <= osc_done;
      end
   end

   // Interrupt request: pending flags gated by enables
   wire [5:0] pend_next = irq_status_rd ? irq_flags
                                        : (pending_q | irq_flags);
   wire       irq_next  = |(pend_next & mask_q[5:0]);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pending_q <= 6'h00;
         irq_q     <= 1'b0;
      end else begin
         // Read clears, but a flag arriving together stays set
         pending_q <= pend_next;
         irq_q     <= irq_next;
      end
   end
   assign irq = irq_q;

   // Read data multiplexer
   wire [7:0] rd_mux = sel_mask ? mask_q
                     : sel_pos ? pos_lo_q
                     : sel_str ? strength_word
                     : sel_t1  ? test1_q
                     : sel_t2  ? test2_q
                     : 8'h00;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_data_q <= 8'h00;
      end else if (rd_en) begin
         rd_data_q <= rd_mux;
      end
   end
   assign rd_data = rd_data_q;

   // Pin and receiver steering
   assign keying_pin_as_decoder_input = test1_q[RSR_T1_KEY_IN];
   assign decoder_in = test1_q[RSR_T1_KEY_IN] &
                       onoff_keying_pin;
   assign tx_keying_pin = test1_q[RSR_T1_SUB_OUT] ? rx_subcarrier
                                                 : tx_modulation;
   assign rx_clear = test1_q[RSR_T1_DIRECT];
   assign stage_select = test1_q[RSR_T1_STAGE];
   assign stage_two_attenuate = test1_q[RSR_T1_ATT2];
   assign stage_one_attenuate = test1_q[RSR_T1_ATT1];
   assign follower_test = test1_q[RSR_T1_FOLLOW];
   assign carrier_level_check = test2_q[RSR_T2_CARRIER];
   assign decoder_test = test2_q[RSR_T2_DEC];
   assign test_mode = test2_q[RSR_T2_DEC] | test2_q[RSR_T2_IO_HI] |
                      test2_q[RSR_T2_IO_LO];
   assign fast_coder_clocking = test2_q[RSR_T2_FASTCLK];
endmodule
`default_nettype wire

// file: tb/rsr_regs_chk.sv
// Assertions on the ports of the status, mask and test register bank.
// Assumes it is bound to rsr_regs and sees only its ports.
`default_nettype none
module rsr_regs_chk (
   input wire logic       sys_clk,   // Clock
   input wire logic       rst,       // Reset
   input wire logic [7:0] addr,      // Address
   input wire logic       wr_en,     // Write strobe
   input wire logic       rd_en,     // Read strobe
   input wire logic [7:0] rd_data,   // Read data
   input wire logic       stop_cond, // Stop
   input wire logic       hit_event, // Hit seen
   input wire logic [5:0] irq_flags, // Flags
   input wire logic       irq_status_rd, // Status read
   input wire logic       irq,       // Request
   input wire logic       onoff_keying_pin, // Pin level
   input wire logic       decoder_in,       // Decoder input
   input wire logic       keying_pin_as_decoder_input, // Pin reuse
   input wire logic       test_mode,    // Test mode
   input wire logic       decoder_test  // Decoder test
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_reset_clears: assert property ($fell(rst) |->
      rd_data == 8'h00 && !irq && !test_mode) else $error("reset state");
   chk_read_holds: assert property (!rd_en |=> $stable(rd_data))
      else $error("read data moved");
   chk_irq_quiet: assert property (
      !irq && irq_flags == 6'h00 |=> !irq) else $error("request rose");
   chk_irq_release: assert property (
      irq_status_rd && irq_flags == 6'h00 |=> !irq) else $error("irq held");
   chk_decoder_gate: assert property (
      decoder_in == (onoff_keying_pin & keying_pin_as_decoder_input))
      else $error("decoder input");
   chk_test_mode_dec: assert property (decoder_test |-> test_mode)
      else $error("test mode low");
   chk_stop_ends: assert property (
      stop_cond && !(wr_en && addr == 8'h1B) |=> !test_mode && !decoder_test)
      else $error("stop ignored");
   chk_pos_lo_clear: assert property (
      rd_en && addr == 8'h0E && !hit_event ##1 !rd_en && !hit_event ##1
      rd_en && addr == 8'h0E && !hit_event |=> rd_data == 8'h00)
      else $error("low kept");
   chk_pos_hi_clear: assert property (
      rd_en && addr == 8'h0D && !hit_event ##1 !rd_en && !hit_event ##1
      rd_en && addr == 8'h0D && !hit_event |=> rd_data[7:6] == 2'b00)
      else $error("high kept");
endmodule
bind rsr_regs rsr_regs_chk u_chk (.sys_clk, .rst, .addr, .wr_en, .rd_en,
   .rd_data, .stop_cond, .hit_event, .irq_flags, .irq_status_rd, .irq,
   .onoff_keying_pin, .decoder_in, .keying_pin_as_decoder_input,
   .test_mode, .decoder_test);
`default_nettype wire

// file: tb/rsr_host.sv
// Host model: master of the register port with read and write tasks.
// Assumes strobes are sampled at the rising edge of sys_clk.
`default_nettype none
module rsr_host (
   input  wire logic       sys_clk, // Clock
   input  wire logic [7:0] rd_data, // Read data
   output logic      [7:0] addr,    // Address
   output logic            wr_en,   // Write strobe
   output logic      [7:0] wr_data, // Write data
   output logic            rd_en    // Read strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {addr, wr_en, wr_data, rd_en} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge sys_clk);
      wr_en = 1'b0;
   endtask
   // Data is taken one cycle after the strobe, never earlier
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge sys_clk);
      rd_en = 1'b0;
      d = rd_data;
   endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the status, mask, strength and test registers.
// Assumes the host model owns the register port.
`default_nettype none
module tb_top;
   import rsr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk, rst, stop_cond, tx_start, rx_active, hit_event;
   logic       irq_status_rd, input_swap, onoff_keying_pin, rx_subcarrier;
   logic       tx_modulation, irq, decoder_in, kp, tx_keying_pin, rx_clear;
   logic       stage_select, s1, s2, ft, cl, test_mode, dt, fc, wr_en, rd_en;
   logic [7:0] addr, wr_data, rd_data, d, m;
   logic [9:0] hit_position;
   logic [5:0] irq_flags;
   logic [2:0] level_a, level_b, gain_level;
   int         miscompares, total_checks, seed, pa, pb;
   rsr_regs u_rsr_regs (.sys_clk, .rst, .addr, .wr_en, .wr_data, .rd_en,
      .rd_data, .stop_cond, .tx_start, .rx_active, .hit_event, .hit_position,
      .irq_flags, .irq_status_rd, .irq, .level_a, .level_b, .gain_level,
      .input_swap, .onoff_keying_pin, .decoder_in, .rx_subcarrier,
      .keying_pin_as_decoder_input(kp), .tx_modulation, .tx_keying_pin,
      .rx_clear, .stage_select, .stage_one_attenuate(s1), .test_mode,
      .stage_two_attenuate(s2), .follower_test(ft), .carrier_level_check(cl),
      .decoder_test(dt), .fast_coder_clocking(fc));
   rsr_host u_rsr_host (.sys_clk, .rd_data, .addr, .wr_en, .wr_data, .rd_en);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string n, input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge sys_clk);
      s = 1'b1;
      @(negedge sys_clk);
      s = 1'b0;
   endtask
   task automatic reset_check;
      logic [7:0] a [6] = '{8'h0D, 8'h0E, 8'h0F, 8'h1A, 8'h1B, 8'h55};
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      foreach (a[i]) begin
         u_rsr_host.rd(a[i], d);
         chk("reset", d, (i == 0) ? 8'h3E : 8'h00);
      end
   endtask
   initial begin
      repeat (25000) @(posedge sys_clk);
      miscompares++;
      summarize;
   end
   initial begin
      {stop_cond, tx_start, rx_active, hit_event, irq_status_rd, input_swap,
       onoff_keying_pin, rx_subcarrier, tx_modulation, hit_position,
       irq_flags, level_a, level_b, gain_level} = '0;
      seed = 62;
      reset_check;
      hit_position = 10'($random(seed));
      pulse(hit_event);
      u_rsr_host.rd(8'h0D, d);
      chk("pos_hi", d, {hit_position[9:8], 6'h3E});
      u_rsr_host.rd(8'h0D, d);
      chk("pos_hi_clr", d, 8'h3E);
      u_rsr_host.rd(8'h0E, d);
      chk("pos_lo", d, hit_position[7:0]);
      u_rsr_host.rd(8'h0E, d);
      chk("pos_lo_clr", d, 8'h00);
      for (int k = 0; k < 2; k++) begin
         m = k ? ~m : 8'($random(seed));
         u_rsr_host.wr(8'h0D, m);
         u_rsr_host.rd(8'h0D, d);
         chk("mask", d, {2'b00, m[5:0]});
         for (int i = 0; i < 6; i++) begin
            @(negedge sys_clk);
            irq_flags = 6'h01 << i;
            @(negedge sys_clk);
            irq_flags = 6'h00;
            chk("irq", 8'(irq), 8'(m[i]));
            pulse(irq_status_rd);
            chk("irq_clr", 8'(irq), 8'h00);
         end
      end
      // Oscillator flag needs the full settle time, it is not shortened
      repeat (RSR_OSC_CYCLES) @(negedge sys_clk);
      for (int k = 0; k < 2; k++) begin
         input_swap = k[0];
         pulse(tx_start);
         rx_active = 1'b1;
         pa = 0;
         pb = 0;
         repeat (8) begin
            level_a = 3'($random(seed));
            level_b = 3'($random(seed));
            @(negedge sys_clk);
            pa = (level_a > pa) ? level_a : pa;
            pb = (level_b > pb) ? level_b : pb;
         end
         rx_active = 1'b0;
         {level_a, level_b} = 6'h3F;
         u_rsr_host.rd(8'h0F, d);
         m = k ? {2'b01, 3'(pa), 3'(pa)} : {2'b01, 3'(pb), 3'(pa)};
         chk("strength", d, m);
      end
      gain_level = 3'($random(seed));
      u_rsr_host.wr(8'h1A, 8'h01);
      u_rsr_host.rd(8'h0F, d);
      chk("agc", d & 8'h07, 8'(gain_level));
      u_rsr_host.wr(8'h1A, 8'h00);
      pulse(tx_start);
      u_rsr_host.wr(8'h0F, 8'hFF);
      u_rsr_host.rd(8'h0F, d);
      chk("strength_clr", d, 8'h40);
      repeat (4) begin
         m = 8'($random(seed));
         {onoff_keying_pin, rx_subcarrier, tx_modulation} = 3'($random(seed));
         u_rsr_host.wr(8'h1A, m);
         u_rsr_host.rd(8'h1A, d);
         chk("test1", d, m);
         chk("pins", {kp, tx_keying_pin, rx_clear, stage_select, s2, s1, ft,
            decoder_in}, {m[7], m[6] ? rx_subcarrier : tx_modulation,
            m[5:1], m[7] & onoff_keying_pin});
      end
      u_rsr_host.wr(8'h1B, 8'h8F);
      chk("test2", {4'h0, cl, test_mode, dt, fc}, 8'h0F);
      pulse(stop_cond);
      u_rsr_host.rd(8'h1B, d);
      chk("stop", d, 8'h81);
      reset_check;
      summarize;
   end
endmodule
`default_nettype wire
